// [logic/ufc_flow_control.sv]
`timescale 1ns/10ps
`default_nettype none
module ufc_flow_control #(
    parameter int BIT_DIV = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic soft_rst_i,
    input wire ufc_pkg::ufc_bus_req_type bus_i,
    output logic [7:0] rdata_o,
    input wire logic cts_i,
    input wire logic dsr_i,
    input wire ufc_pkg::ufc_char_type rx_char_i,
    input wire logic fifo_halt_i,
    input wire logic fifo_resume_i,
    input wire logic tx_ready_i,
    input wire logic tx_bit_start_i,
    input wire logic tx_last_done_i,
    output logic tx_allow_o,
    output logic tx_go_o,
    output logic send_xon_o,
    output logic send_xoff_o,
    output logic rts_o,
    output logic dtr_o,
    output logic rx_enable_o
);
    import ufc_pkg::*;

    logic [7:0] flow_cfg_q;
    logic [7:0] modem_ctl_q;
    logic [7:0] xon_q;
    logic [7:0] xoff_q;
    logic xoff_seen_q;
    logic rx_halted_q;
    // Width of the bit-time divider, worked out once so that every use agrees.
    localparam int DIV_W = $clog2(BIT_DIV);
    logic [DIV_W-1:0] div_q;
    logic [BIT_CNT_W-1:0] lead_q;
    ufc_hdx_state_type hdx_q;
    ufc_hdx_state_type hdx_d;
    logic rts_d;
    logic dtr_d;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    wire wr_cfg = bus_i.write && hit(bus_i.addr, OFS_FLOW_CFG);
    wire wr_mc = bus_i.write && hit(bus_i.addr, OFS_MODEM_CTL);
    wire wr_xon = bus_i.write && hit(bus_i.addr, OFS_XON_CODE);
    wire wr_xoff = bus_i.write && hit(bus_i.addr, OFS_XOFF_CODE);
    wire illegal_mix = bus_i.wdata[FC_TX_ANY] && bus_i.wdata[FC_TX_SOFT];
    wire [7:0] cfg_wr_val = illegal_mix ? (bus_i.wdata & 8'hFC) : bus_i.wdata;

    wire tx_soft_flow_en = flow_cfg_q[FC_TX_SOFT];
    wire tx_resume_any_en = flow_cfg_q[FC_TX_ANY];
    wire cts_en = flow_cfg_q[FC_CTS];
    wire dsr_en = flow_cfg_q[FC_DSR];
    wire rx_soft_flow_en = flow_cfg_q[FC_RX_SOFT];
    wire rts_flow_en = flow_cfg_q[FC_RTS];
    wire dtr_flow_en = flow_cfg_q[FC_DTR];
    wire half_duplex_line_en = flow_cfg_q[FC_HDX];
    wire rx_keep_enabled = modem_ctl_q[MC_RX_KEEP];

    // Received characters are compared with the codes only when matching is on.
    wire match_on = rx_soft_flow_en || tx_soft_flow_en || tx_resume_any_en;
    wire is_xoff = match_on && rx_char_i.valid && (rx_char_i.data == xoff_q);
    wire is_xon = match_on && rx_char_i.valid && (rx_char_i.data == xon_q);
    wire soft_mode = tx_soft_flow_en || tx_resume_any_en;
    wire resume_ev = tx_resume_any_en ? (rx_char_i.valid && !is_xoff) : is_xon;
    wire xoff_d = !soft_mode ? 1'b0 :
        is_xoff ? 1'b1 : (resume_ev ? 1'b0 : xoff_seen_q);
    wire hw_halt = (cts_en && cts_i) || (dsr_en && dsr_i);
    wire allow_d = !hw_halt && !xoff_d;

    wire halt_d = fifo_halt_i ? 1'b1 : (fifo_resume_i ? 1'b0 : rx_halted_q);
    // The divider runs only during the lead, so every lead starts on a fresh bit time.
    wire bit_tick = (div_q == DIV_W'(BIT_DIV - 1));

    // Transceiver sequence: idle, a lead of two bit times, send, then one tail cycle.
    // Clearing half duplex drops the sequence at once; RTS and DTR then follow the flow and manual modem control bits.
    always_comb begin
        hdx_d = hdx_q;
        case (hdx_q)
            UFC_IDLE: begin
                if (half_duplex_line_en && tx_ready_i) begin
                    hdx_d = UFC_LEAD;
                end
            end
            UFC_LEAD: begin
                if (bit_tick && lead_q == BIT_CNT_W'(LEAD_BITS - 1)) begin
                    hdx_d = UFC_SEND;
                end
            end
            UFC_SEND: begin
                if (tx_last_done_i && !tx_ready_i) begin
                    hdx_d = UFC_TAIL;
                end
            end
            UFC_TAIL: hdx_d = UFC_IDLE;
            default: hdx_d = UFC_IDLE;
        endcase
        if (!half_duplex_line_en) begin
            hdx_d = UFC_IDLE;
        end
    end

    // The next state is used so that the pins move on the same edge as the sequence.
    wire line_busy = (hdx_d == UFC_LEAD) || (hdx_d == UFC_SEND);
    wire rx_gate = rx_keep_enabled || !line_busy;

    always_comb begin
        if (half_duplex_line_en) begin
            rts_d = line_busy;
            dtr_d = !line_busy;
        end else begin
            rts_d = rts_flow_en ? halt_d : !modem_ctl_q[MC_RTS];
            dtr_d = dtr_flow_en ? halt_d : !modem_ctl_q[MC_DTR];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flow_cfg_q <= FLOW_CFG_RST;
            modem_ctl_q <= MODEM_CTL_RST;
            xon_q <= XON_RST;
            xoff_q <= XOFF_RST;
        end else if (soft_rst_i) begin
            flow_cfg_q <= FLOW_CFG_RST;
            modem_ctl_q <= MODEM_CTL_RST;
        end else begin
            if (wr_cfg) begin
                flow_cfg_q <= cfg_wr_val;
            end
            if (wr_mc) begin
                modem_ctl_q <= bus_i.wdata;
            end
            if (wr_xon) begin
                xon_q <= bus_i.wdata;
            end
            if (wr_xoff) begin
                xoff_q <= bus_i.wdata;
            end
        end
    end

    // Xoff and Xon requests are single-cycle pulses on the edges of the halt level.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            xoff_seen_q <= 1'b0;
            tx_allow_o <= 1'b1;
            rx_halted_q <= 1'b0;
            send_xon_o <= 1'b0;
            send_xoff_o <= 1'b0;
        end else if (soft_rst_i) begin
            xoff_seen_q <= 1'b0;
            tx_allow_o <= 1'b1;
            rx_halted_q <= 1'b0;
            send_xon_o <= 1'b0;
            send_xoff_o <= 1'b0;
        end else begin
            xoff_seen_q <= xoff_d;
            tx_allow_o <= allow_d;
            rx_halted_q <= halt_d;
            send_xoff_o <= rx_soft_flow_en && halt_d && !rx_halted_q;
            send_xon_o <= rx_soft_flow_en && !halt_d && rx_halted_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hdx_q <= UFC_IDLE;
            div_q <= '0;
            lead_q <= '0;
            tx_go_o <= 1'b0;
            rts_o <= 1'b1;
            dtr_o <= 1'b1;
            rx_enable_o <= 1'b1;
        end else begin
            hdx_q <= hdx_d;
            div_q <= (hdx_q != UFC_LEAD || bit_tick) ? '0 : div_q + 1'b1;
            if (hdx_q != UFC_LEAD) begin
                lead_q <= '0;
            end else if (bit_tick) begin
                lead_q <= lead_q + 1'b1;
            end
            tx_go_o <= half_duplex_line_en ? (hdx_d == UFC_SEND) && allow_d : allow_d;
            rts_o <= rts_d;
            dtr_o <= dtr_d;
            rx_enable_o <= rx_gate;
        end
    end

    wire [7:0] status_val = {3'h0, hdx_q == UFC_SEND, hdx_q == UFC_LEAD,
        rx_halted_q, xoff_seen_q, tx_allow_o};

    // Unmapped reads and idle cycles return zero, so stale read data never lingers.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.read) begin
            case (bus_i.addr)
                OFS_FLOW_CFG: rdata_o <= flow_cfg_q;
                OFS_MODEM_CTL: rdata_o <= modem_ctl_q;
                OFS_XON_CODE: rdata_o <= xon_q;
                OFS_XOFF_CODE: rdata_o <= xoff_q;
                OFS_STATUS: rdata_o <= status_val;
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    chk_cts_halts: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (cts_en && cts_i && !soft_rst_i && !wr_cfg) |=> !tx_allow_o)
        else $error("Transmit allowed while CTS halts it.");
    chk_dsr_halts: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (dsr_en && dsr_i && !soft_rst_i && !wr_cfg) |=> !tx_allow_o)
        else $error("Transmit allowed while DSR halts it.");
    chk_xoff_stops: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (tx_soft_flow_en && is_xoff && !soft_rst_i && !wr_cfg) |=> !tx_allow_o)
        else $error("Xoff did not stop transmit.");
    chk_mix_cleared: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !(flow_cfg_q[FC_TX_ANY] && flow_cfg_q[FC_TX_SOFT]))
        else $error("Xon-any and soft enable both set.");
    chk_hdx_opposite: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $past(half_duplex_line_en) && !$past(soft_rst_i) |-> (rts_o != dtr_o))
        else $error("RTS and DTR not opposite in half duplex.");
    chk_lead_time: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (hdx_q == UFC_IDLE && hdx_d == UFC_LEAD) |=> rts_o && !tx_go_o)
        else $error("Line not enabled ahead of transmit.");
    chk_rts_halt: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!half_duplex_line_en && rts_flow_en && fifo_halt_i && !soft_rst_i && !wr_cfg)
        |=> rts_o)
        else $error("RTS not raised at halt level.");
    chk_rx_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (half_duplex_line_en && !rx_keep_enabled && hdx_q == UFC_SEND
            && !soft_rst_i && !wr_cfg && !wr_mc) |=> (!rx_enable_o || !rts_o))
        else $error("Receiver enabled while driving line.");

    // Flow-controlled pins follow the receive FIFO levels one cycle later.
    chk_dtr_halt: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!half_duplex_line_en && dtr_flow_en && fifo_halt_i && !soft_rst_i && !wr_cfg)
        |=> dtr_o)
        else $error("DTR not raised at halt level.");
    chk_rts_resume: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!half_duplex_line_en && rts_flow_en && !fifo_halt_i && fifo_resume_i && !soft_rst_i
            && !wr_cfg) |=> !rts_o)
        else $error("RTS not lowered at resume level.");
    chk_dtr_resume: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!half_duplex_line_en && dtr_flow_en && !fifo_halt_i && fifo_resume_i && !soft_rst_i
            && !wr_cfg) |=> !dtr_o)
        else $error("DTR not lowered at resume level.");
    // Xoff and Xon requests accompany the halt and resume edges.
    chk_xoff_sent: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (rx_soft_flow_en && fifo_halt_i && !rx_halted_q && !soft_rst_i)
        |=> send_xoff_o)
        else $error("Xoff request missing at halt level.");
    chk_xon_sent: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (rx_soft_flow_en && !fifo_halt_i && fifo_resume_i && rx_halted_q && !soft_rst_i)
        |=> send_xon_o)
        else $error("Xon request missing at resume level.");
    // Half-duplex pin levels outside a transfer.
    chk_line_release: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (half_duplex_line_en && hdx_q == UFC_SEND && tx_last_done_i && !tx_ready_i)
        |=> (!rts_o && dtr_o))
        else $error("Line not released after last bit.");
    chk_manual_ignored: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (half_duplex_line_en && hdx_q == UFC_IDLE && !tx_ready_i)
        |=> (!rts_o && dtr_o))
        else $error("Manual pin bits acted in half duplex.");
    // Transmit gating by received characters and by soft reset.
    chk_any_resumes: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (tx_resume_any_en && rx_char_i.valid && !is_xoff && !hw_halt && !soft_rst_i
            && !wr_cfg) |=> tx_allow_o)
        else $error("Any character did not resume transmit.");
    chk_xoff_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (tx_soft_flow_en && xoff_seen_q && !is_xon && !soft_rst_i && !wr_cfg)
        |=> !tx_allow_o)
        else $error("Transmit resumed while Xoff still holds.");
    chk_soft_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        soft_rst_i
        |=> (flow_cfg_q == FLOW_CFG_RST && tx_allow_o && !xoff_seen_q))
        else $error("Soft reset left flow control active.");
endmodule : ufc_flow_control
`default_nettype wire

// [logic/ufc_pkg.sv]
`default_nettype none
package ufc_pkg;
    // Register map of the flow-control block on the plain register port.
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_FLOW_CFG = 4'h0;
    localparam logic [3:0] OFS_MODEM_CTL = 4'h1;
    localparam logic [3:0] OFS_XON_CODE = 4'h2;
    localparam logic [3:0] OFS_XOFF_CODE = 4'h3;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    // Field positions of flow_control_config.
    localparam int FC_TX_SOFT = 0;
    localparam int FC_TX_ANY = 1;
    localparam int FC_CTS = 2;
    localparam int FC_DSR = 3;
    localparam int FC_RX_SOFT = 4;
    localparam int FC_RTS = 5;
    localparam int FC_DTR = 6;
    localparam int FC_HDX = 7;
    // Field positions of modem_control_reg.
    localparam int MC_RX_KEEP = 1;
    localparam int MC_DTR = 4;
    localparam int MC_RTS = 5;
    // Reset values.
    localparam logic [7:0] FLOW_CFG_RST = 8'h00;
    localparam logic [7:0] MODEM_CTL_RST = 8'h00;
    localparam logic [7:0] XON_RST = 8'h11;
    localparam logic [7:0] XOFF_RST = 8'h13;
    // Timing: lead time of the transceiver enable, in bit times.
    localparam int LEAD_BITS = 2;
    localparam int BIT_CNT_W = 2;
    typedef enum logic [1:0] {
        UFC_IDLE,
        UFC_LEAD,
        UFC_SEND,
        UFC_TAIL
    } ufc_hdx_state_type;
    typedef struct packed {
        logic write;
        logic read;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } ufc_bus_req_type;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ufc_char_type;
endpackage : ufc_pkg
`default_nettype wire

// [bench/ufc_peer.sv]
`timescale 1ns/10ps
`default_nettype none
module ufc_peer (
    input wire logic ref_clk_i,
    input wire logic cts_hold_i,
    input wire logic dsr_hold_i,
    input wire logic send_i,
    input wire logic [7:0] code_i,
    output logic cts_o,
    output logic dsr_o,
    output ufc_pkg::ufc_char_type char_o
);
    import ufc_pkg::*;
    // Data lines toggle between characters so a stale code never looks valid.
    always @(posedge ref_clk_i) begin
        cts_o <= cts_hold_i;
        dsr_o <= dsr_hold_i;
        char_o.valid <= send_i;
        char_o.data <= send_i ? code_i : ~char_o.data;
    end
endmodule : ufc_peer
`default_nettype wire

// [bench/uart_flow_control_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module uart_flow_control_tb;
    import ufc_pkg::*;
    localparam int BD = 4;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic soft_rst_i = 1'b0;
    ufc_bus_req_type bus_i = '0;
    ufc_char_type rx_char;
    logic [7:0] rdata_o, code = 8'h00;
    logic cts_i, dsr_i, cts_hold = 1'b0, dsr_hold = 1'b0, send = 1'b0;
    logic halt = 1'b0, resume = 1'b0, tx_ready = 1'b0, last_done = 1'b0;
    logic tx_allow_o, tx_go_o, send_xon_o, send_xoff_o, rts_o, dtr_o, rx_enable_o;
    int err_total = 0;
    int n_compared = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    ufc_peer u_peer (.ref_clk_i(ref_clk_i), .cts_hold_i(cts_hold), .dsr_hold_i(dsr_hold),
        .send_i(send), .code_i(code), .cts_o(cts_i), .dsr_o(dsr_i), .char_o(rx_char));
    ufc_flow_control #(.BIT_DIV(BD)) u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .soft_rst_i(soft_rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .cts_i(cts_i),
        .dsr_i(dsr_i), .rx_char_i(rx_char), .fifo_halt_i(halt), .fifo_resume_i(resume),
        .tx_ready_i(tx_ready), .tx_bit_start_i(1'b0), .tx_last_done_i(last_done),
        .tx_allow_o(tx_allow_o), .tx_go_o(tx_go_o), .send_xon_o(send_xon_o),
        .send_xoff_o(send_xoff_o), .rts_o(rts_o), .dtr_o(dtr_o), .rx_enable_o(rx_enable_o));
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : settle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        bus_i <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_i);
        bus_i <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        bus_i <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk_i);
        bus_i <= '0;
        @(negedge ref_clk_i);
        chk($sformatf("rdata %h", a), e, rdata_o);
    endtask : rd
    // Order of the packed pin view: allow, rts, dtr, receiver enable.
    task automatic pins(input logic [3:0] e);
        chk("pins", {4'h0, e}, {4'h0, tx_allow_o, rts_o, dtr_o, rx_enable_o});
    endtask : pins
    task automatic allow(input logic e);
        settle(3);
        chk("allow", {7'h00, e}, {7'h00, tx_allow_o});
        chk("go", {7'h00, e}, {7'h00, tx_go_o});
    endtask : allow
    task automatic peer(input logic c, input logic d);
        @(posedge ref_clk_i);
        cts_hold <= c;
        dsr_hold <= d;
    endtask : peer
    task automatic chr(input logic [7:0] k);
        @(posedge ref_clk_i);
        send <= 1'b1;
        code <= k;
        @(posedge ref_clk_i);
        send <= 1'b0;
    endtask : chr
    task automatic fifo(input logic h, input logic r);
        @(posedge ref_clk_i);
        halt <= h;
        resume <= r;
    endtask : fifo
    task automatic pulses(input string w, input bit x, input logic [7:0] n);
        int hit;
        hit = 0;
        repeat (6) begin
            @(negedge ref_clk_i);
            if ((x ? send_xoff_o : send_xon_o) === 1'b1) hit++;
        end
        chk(w, n, hit[7:0]);
    endtask : pulses
    task automatic t_reset();
        rd(OFS_FLOW_CFG, FLOW_CFG_RST);
        rd(OFS_MODEM_CTL, MODEM_CTL_RST);
        rd(OFS_XON_CODE, XON_RST);
        rd(OFS_XOFF_CODE, XOFF_RST);
        rd(4'hF, 8'h00);
        pins(4'hF);
    endtask : t_reset
    task automatic t_modem();
        for (int i = 0; i < 2; i++) begin
            wr(OFS_FLOW_CFG, 8'h04 << i);
            peer(i[0], !i[0]);
            allow(1'b1);
            peer(!i[0], i[0]);
            allow(1'b0);
            peer(1'b0, 1'b0);
            allow(1'b1);
        end
    endtask : t_modem
    task automatic t_soft();
        wr(OFS_FLOW_CFG, 8'h00);
        chr(XOFF_RST);
        allow(1'b1);
        wr(OFS_FLOW_CFG, 8'h01);
        chr(XOFF_RST);
        allow(1'b0);
        chr(8'h41);
        allow(1'b0);
        chr(XON_RST);
        allow(1'b1);
        wr(OFS_FLOW_CFG, 8'h02);
        chr(XOFF_RST);
        allow(1'b0);
        chr(8'h41);
        allow(1'b1);
        wr(OFS_FLOW_CFG, 8'h0F);
        rd(OFS_FLOW_CFG, 8'h0C);
        wr(OFS_FLOW_CFG, 8'h05);
        peer(1'b1, 1'b0);
        chr(XOFF_RST);
        peer(1'b0, 1'b0);
        allow(1'b0);
        chr(XON_RST);
        allow(1'b1);
        wr(OFS_FLOW_CFG, 8'h04);
        peer(1'b1, 1'b0);
        @(posedge ref_clk_i);
        soft_rst_i <= 1'b1;
        @(posedge ref_clk_i);
        soft_rst_i <= 1'b0;
        rd(OFS_FLOW_CFG, 8'h00);
        allow(1'b1);
        peer(1'b0, 1'b0);
    endtask : t_soft
    task automatic t_rx();
        wr(OFS_FLOW_CFG, 8'h60);
        fifo(1'b1, 1'b0);
        settle(3);
        pins(4'hF);
        fifo(1'b0, 1'b1);
        settle(3);
        pins(4'h9);
        fifo(1'b0, 1'b0);
        wr(OFS_FLOW_CFG, 8'h20);
        fifo(1'b1, 1'b0);
        pulses("xoff", 1'b1, 8'h00);
        fifo(1'b0, 1'b1);
        wr(OFS_FLOW_CFG, 8'h30);
        fifo(1'b1, 1'b0);
        pulses("xoff", 1'b1, 8'h01);
        pins(4'hF);
        fifo(1'b0, 1'b1);
        pulses("xon", 1'b0, 8'h01);
        pins(4'hB);
        fifo(1'b0, 1'b0);
    endtask : t_rx
    task automatic t_hdx();
        int n;
        wr(OFS_MODEM_CTL, 8'h30);
        wr(OFS_FLOW_CFG, 8'h80);
        settle(2);
        pins(4'hB);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_MODEM_CTL, k[0] ? 8'h32 : 8'h30);
            @(posedge ref_clk_i);
            tx_ready <= 1'b1;
            settle(2);
            pins(k[0] ? 4'hD : 4'hC);
            n = 2;
            while (tx_go_o !== 1'b1 && n < 40) begin
                @(negedge ref_clk_i);
                n++;
            end
            chk("lead", 8'h01, {7'h00, n > 2 * BD && n < 2 * BD + 4});
            @(posedge ref_clk_i);
            tx_ready <= 1'b0;
            last_done <= 1'b1;
            @(posedge ref_clk_i);
            last_done <= 1'b0;
            settle(2);
            pins(4'hB);
        end
        wr(OFS_FLOW_CFG, 8'h00);
        settle(2);
        pins(4'h9);
    endtask : t_hdx
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #3000000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_modem();
        t_soft();
        t_rx();
        t_hdx();
        wrap_up();
    end
endmodule : uart_flow_control_tb
`default_nettype wire
